/* File: usb_flow_consts.svh */
// What this block does
// - control count 16 bits, general 32 bits
// - out packet is min(count, max length)
// - start out only with packet in fifo
// - out count drops by bytes sent
// - count zero stops run, sets done flag
// - in expects min(count, max length)
// - issue in only with packet space free
// - in count drops by bytes received
// - oversize: result, flag, fifo kept, stop unless iso
// - short: result, flag, space reserved, stop unless iso
// - cpu writes selected area, sent in order
// - full area refuses writes, free reported
// - cpu reads selected area in order
// - dma remaining shown, pauses when empty
// - empty packet option general out only
// - boundary end keeps run with option, bulk or interrupt only
// - next schedule sends zero length out
// - zero length done stops run, flags
// - first general channel bulk only
//
// Purpose: offsets, field positions and codes of the channel data-flow engine
// Assumes: 32-bit classic wishbone, byte addresses
// Notes:   definitions only
`ifndef USB_FLOW_CONSTS_SVH
`define USB_FLOW_CONSTS_SVH

// ----------------------------------------
// channel count and widths
// ----------------------------------------
`define NUM_CHAN       6
`define CTRL_COUNT_W   16
`define MPL_W          11

// ----------------------------------------
// global and channel register offsets
// ----------------------------------------
`define ADR_AREA_SEL   16'h0000
`define ADR_FREE_CNT   16'h0004
`define ADR_READ_CNT   16'h0008
`define ADR_BYTE_WR    16'h000C
`define ADR_BYTE_RD    16'h0010
`define ADR_WORD_WR    16'h0014
`define ADR_WORD_RD    16'h0018
`define ADR_DMA_REMAIN 16'h001C
`define CHAN_PAGE      8'h01
`define OFS_CONFIG     4'h0
`define OFS_REMAIN     4'h4
`define OFS_STATUS     4'h8

// ----------------------------------------
// field positions
// ----------------------------------------
`define SEL_WR         0
`define SEL_RD         4
`define SEL_DMA        8
`define SEL_DMA_DIR    12
`define CFG_RUN        0
`define CFG_DIR        1
`define CFG_TYPE       2
`define CFG_AZLP       4
`define CFG_AREA       8
`define CFG_MPL        16
`define STS_DONE       0
`define STS_COND       1
`define STS_RES        8

// ----------------------------------------
// result codes
// ----------------------------------------
`define RES_OK         4'h0
`define RES_OVERSIZE   4'h8
`define RES_SHORT      4'h9

`endif

/* File: usb_flow_pkg.sv */
// Purpose: types of the channel data-flow engine
// Assumes: nothing beyond the constants header
// Notes:   channel state travels as one packed record
package usb_flow_pkg;
  typedef enum logic [1:0] {TYPE_CTRL, TYPE_BULK, TYPE_INTR, TYPE_ISO} chan_type_e;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_BUSY} eng_state_e;
  typedef struct packed {
    logic [2:0]  chan;
    logic        dir_in;
    logic        zero_len;
    logic [15:0] length;
  } txn_req_s;
  typedef struct packed {
    logic [3:0]  result;
    logic [15:0] length;
  } txn_res_s;
  typedef struct packed {
    logic        transfer_run;
    logic        dir_in;
    chan_type_e  ctype;
    logic        auto_empty_packet_enable;
    logic        empty_packet_pending;
    logic [2:0]  area;
    logic [10:0] max_packet_length;
    logic [31:0] transfer_remaining_count;
    logic        transfer_count_done_flag;
    logic        condition_change_flag;
    logic [3:0]  result_code;
  } chan_s;
endpackage

/* File: usb_host_channel_data_flow.sv */
// Purpose: per-channel out/in data flow with fifo areas, cpu and dma ports
// Assumes: link partner runs each transaction and reports length and result
// Notes:   word ports move one byte per cycle, ack after the fourth
//
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`include "usb_flow_consts.svh"
module usb_host_channel_data_flow
  import usb_flow_pkg::*;
#(
  parameter int AREAS = 6,
  parameter int DEPTH = 64
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // transaction link
  output logic             txn_valid,
  input  wire logic        txn_ready,
  output txn_req_s         txn_req,
  input  wire logic        txn_done,
  input  wire txn_res_s    txn_res,
  input  wire logic        tx_pop,
  output logic      [7:0]  tx_byte,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  // dma read
  input  wire logic        dma_req,
  output logic             dma_ack,
  output logic      [7:0]  dma_data,
  output logic             dma_pause,
  output logic      [31:0] dma_remaining_count
);
  localparam int NCH = `NUM_CHAN;
  localparam int AW  = $clog2(DEPTH);
  localparam int CW  = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  chan_s            ch_reg   [NCH];
  chan_s            ch_next  [NCH];
  logic [7:0]       mem_reg  [AREAS][DEPTH];
  logic [7:0]       mem_next [AREAS][DEPTH];
  logic [AW-1:0]    wp_reg   [AREAS];
  logic [AW-1:0]    wp_next  [AREAS];
  logic [AW-1:0]    rp_reg   [AREAS];
  logic [AW-1:0]    rp_next  [AREAS];
  logic [CW-1:0]    cnt_reg  [AREAS];
  logic [CW-1:0]    cnt_next [AREAS];
  logic [12:0]      sel_reg, sel_next;
  eng_state_e       st_reg, st_next;
  logic [2:0]       act_reg, act_next, rr_reg, rr_next;
  txn_req_s         req_reg, req_next;
  logic [AW-1:0]    snap_reg, snap_next;
  logic [CW-1:0]    rxc_reg, rxc_next;
  logic             ack_reg, ack_next;
  logic [31:0]      dat_reg, dat_next;
  logic [1:0]       step_reg, step_next;
  logic [7:0]       txb_reg, txb_next, dmab_reg, dmab_next;
  logic [15:0]      pkt_sz   [NCH];
  logic [NCH-1:0]   elig;
  logic             pick_ok;
  logic [2:0]       pick, ua, wa, ra, da;
  logic             upush, upop;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (s[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  function automatic logic [2:0] area_fix(input logic [2:0] a);
    return (int'(a) < AREAS) ? a : 3'h0;
  endfunction

  function automatic logic [31:0] cfg_word(input chan_s c);
    logic [31:0] w;
    w = '0;
    w[`CFG_RUN]           = c.transfer_run;
    w[`CFG_DIR]           = c.dir_in;
    w[`CFG_TYPE +: 2]     = c.ctype;
    w[`CFG_AZLP]          = c.auto_empty_packet_enable;
    w[`CFG_AREA +: 3]     = c.area;
    w[`CFG_MPL +: `MPL_W] = c.max_packet_length;
    return w;
  endfunction

  assign ua = ch_reg[act_reg].area;
  assign wa = sel_reg[`SEL_WR +: 3];
  assign ra = sel_reg[`SEL_RD +: 3];
  assign da = sel_reg[`SEL_DMA +: 3];
  assign upush = (st_reg == ST_BUSY) & req_reg.dir_in & rx_valid & (cnt_reg[ua] != FULL);
  assign upop  = (st_reg == ST_BUSY) & ~req_reg.dir_in & tx_pop & (cnt_reg[ua] != '0);
  assign dma_pause = ~sel_reg[`SEL_DMA_DIR] | (cnt_reg[da] == '0);
  assign dma_ack   = dma_req & ~dma_pause & ~(upop & (ua == da));
  assign dma_remaining_count = 32'(cnt_reg[da]);
  assign txn_valid = (st_reg == ST_ISSUE);
  assign txn_req   = req_reg;
  assign tx_byte   = txb_reg;
  assign dma_data  = dmab_reg;
  assign dat_o     = dat_reg;
  assign ack_o     = ack_reg;

  // ----------------------------------------
  // packet sizing and eligibility
  // ----------------------------------------
  always_comb begin
    int idx;
    idx = 0;
    for (int c = 0; c < NCH; c++) begin
      // smaller of count and max, zero pending
      if (ch_reg[c].empty_packet_pending)
        pkt_sz[c] = 16'h0000;
      else if (ch_reg[c].transfer_remaining_count < 32'(ch_reg[c].max_packet_length))
        pkt_sz[c] = ch_reg[c].transfer_remaining_count[15:0];
      else
        pkt_sz[c] = 16'(ch_reg[c].max_packet_length);
      if (!ch_reg[c].transfer_run)
        elig[c] = 1'b0;
      else if (ch_reg[c].dir_in)
        // free space for a whole max packet
        elig[c] = (ch_reg[c].transfer_remaining_count != '0) &&
                  (16'(FULL - cnt_reg[ch_reg[c].area]) >= 16'(ch_reg[c].max_packet_length));
      else
        elig[c] = ch_reg[c].empty_packet_pending ||
                  ((ch_reg[c].transfer_remaining_count != '0) &&
                   (16'(cnt_reg[ch_reg[c].area]) >= pkt_sz[c]));
    end
    // round robin from the channel after the last one served
    pick_ok = 1'b0;
    pick    = 3'h0;
    for (int k = NCH; k >= 1; k--) begin
      idx = (int'(rr_reg) + k) % NCH;
      if (elig[idx]) begin
        pick_ok = 1'b1;
        pick    = 3'(idx);
      end
    end
  end

  // ----------------------------------------
  // bus, fifo and engine next state
  // ----------------------------------------
  always_comb begin
    logic        req, port, word, last, go, over, shrt, chit;
    logic [1:0]  lane;
    logic [2:0]  ci;
    logic [7:0]  cb;
    logic [31:0] w, rem_new;
    ch_next = ch_reg;   mem_next = mem_reg; wp_next = wp_reg; rp_next = rp_reg;
    cnt_next = cnt_reg; sel_next = sel_reg; st_next = st_reg; act_next = act_reg;
    rr_next = rr_reg;   req_next = req_reg; snap_next = snap_reg; rxc_next = rxc_reg;
    step_next = step_reg; dat_next = dat_reg; ack_next = 1'b0; txb_next = txb_reg;
    dmab_next = dmab_reg;
    over = 1'b0; shrt = 1'b0; rem_new = '0; cb = 8'h00; w = '0;
    req = 1'b0; port = 1'b0; word = 1'b0; last = 1'b0; go = 1'b0; chit = 1'b0; lane = 2'd0; ci = 3'd0;
    // link and dma move first; a cpu write waits on a link push, a cpu read on a link pop or dma read, of its area
    if (upush) begin
      mem_next[ua][wp_next[ua]] = rx_byte;
      wp_next[ua]  = wp_next[ua] + 1'b1;
      cnt_next[ua] = cnt_next[ua] + 1'b1;
      rxc_next     = rxc_reg + 1'b1;
    end
    if (upop) begin
      rp_next[ua]  = rp_next[ua] + 1'b1;
      cnt_next[ua] = cnt_next[ua] - 1'b1;
    end
    if (dma_ack) begin
      dmab_next    = mem_reg[da][rp_next[da]];
      rp_next[da]  = rp_next[da] + 1'b1;
      cnt_next[da] = cnt_next[da] - 1'b1;
    end
    req  = cyc_i & stb_i & ~ack_reg;
    word = (adr_i == `ADR_WORD_WR) | (adr_i == `ADR_WORD_RD);
    port = req & (word | (adr_i == `ADR_BYTE_WR) | (adr_i == `ADR_BYTE_RD));
    go   = port & ~(we_i ? (upush & (ua == wa))
                         : ((upop & (ua == ra)) | (dma_ack & (da == ra))));
    last = ~word | (step_reg == 2'd3);
    lane = word ? step_reg : 2'd0;
    if (go) begin
      if (we_i) begin
        // in order into write area, full drops
        if ((cnt_next[wa] != FULL) && sel_i[lane]) begin
          mem_next[wa][wp_next[wa]] = dat_i[{lane, 3'b000} +: 8];
          wp_next[wa]  = wp_next[wa] + 1'b1;
          cnt_next[wa] = cnt_next[wa] + 1'b1;
        end
      end else begin
        // in order from read area, empty gives zero
        if (cnt_next[ra] != '0) begin
          cb = mem_reg[ra][rp_next[ra]];
          rp_next[ra]  = rp_next[ra] + 1'b1;
          cnt_next[ra] = cnt_next[ra] - 1'b1;
        end
        if (step_reg == 2'd0) dat_next = {24'h00_0000, cb};
        else dat_next[{step_reg, 3'b000} +: 8] = cb;
      end
      step_next = last ? 2'd0 : step_reg + 2'd1;
      ack_next  = last;
    end
    chit = (adr_i[15:8] == `CHAN_PAGE) & ~adr_i[7] & (int'(adr_i[6:4]) < NCH);
    ci   = adr_i[6:4];
    if (req & ~port) begin
      ack_next = 1'b1;
      dat_next = 32'h0000_0000;
      if (we_i) begin
        if (adr_i == `ADR_AREA_SEL) begin
          w = merge(32'(sel_reg), dat_i, sel_i);
          sel_next = w[12:0];
          sel_next[`SEL_WR +: 3]  = area_fix(w[`SEL_WR +: 3]);
          sel_next[`SEL_RD +: 3]  = area_fix(w[`SEL_RD +: 3]);
          sel_next[`SEL_DMA +: 3] = area_fix(w[`SEL_DMA +: 3]);
        end else if (chit && adr_i[3:0] == `OFS_CONFIG) begin
          w = merge(cfg_word(ch_reg[ci]), dat_i, sel_i);
          ch_next[ci].transfer_run      = w[`CFG_RUN];
          ch_next[ci].dir_in            = w[`CFG_DIR];
          ch_next[ci].area              = area_fix(w[`CFG_AREA +: 3]);
          ch_next[ci].max_packet_length = w[`CFG_MPL +: `MPL_W];
          ch_next[ci].ctype             = chan_type_e'(w[`CFG_TYPE +: 2]);
          ch_next[ci].auto_empty_packet_enable = w[`CFG_AZLP] & (ci != 3'd0);
          if (ci == 3'd0) ch_next[ci].ctype = TYPE_CTRL;
          if (ci == 3'd1) ch_next[ci].ctype = TYPE_BULK;
        end else if (chit && adr_i[3:0] == `OFS_REMAIN) begin
          w = merge(ch_reg[ci].transfer_remaining_count, dat_i, sel_i);
          if (ci == 3'd0) w[31:`CTRL_COUNT_W] = '0;
          ch_next[ci].transfer_remaining_count = w;
          ch_next[ci].empty_packet_pending     = 1'b0;
        end else if (chit && adr_i[3:0] == `OFS_STATUS && sel_i[0]) begin
          // flags leave only on a one written
          if (dat_i[`STS_DONE]) ch_next[ci].transfer_count_done_flag = 1'b0;
          if (dat_i[`STS_COND]) ch_next[ci].condition_change_flag    = 1'b0;
        end
      end else if (adr_i == `ADR_AREA_SEL) dat_next = 32'(sel_reg);
      else if (adr_i == `ADR_FREE_CNT) dat_next = 32'(FULL - cnt_reg[wa]);
      else if (adr_i == `ADR_READ_CNT) dat_next = 32'(cnt_reg[ra]);
      else if (adr_i == `ADR_DMA_REMAIN) dat_next = dma_remaining_count;
      else if (chit && adr_i[3:0] == `OFS_CONFIG) dat_next = cfg_word(ch_reg[ci]);
      else if (chit && adr_i[3:0] == `OFS_REMAIN)
        dat_next = ch_reg[ci].transfer_remaining_count;
      else if (chit && adr_i[3:0] == `OFS_STATUS) begin
        dat_next[`STS_DONE]     = ch_reg[ci].transfer_count_done_flag;
        dat_next[`STS_COND]     = ch_reg[ci].condition_change_flag;
        dat_next[`STS_RES +: 4] = ch_reg[ci].result_code;
      end
    end
    // engine runs after the bus so hardware events win over clears
    unique case (st_reg)
      ST_IDLE: if (pick_ok) begin
        act_next  = pick;
        req_next  = '{chan: pick, dir_in: ch_reg[pick].dir_in,
                      zero_len: ch_reg[pick].empty_packet_pending, length: pkt_sz[pick]};
        snap_next = wp_reg[ch_reg[pick].area];
        rxc_next  = '0;
        st_next   = ST_ISSUE;
      end
      ST_ISSUE: if (txn_ready) st_next = ST_BUSY;
      ST_BUSY: if (txn_done) begin
        st_next = ST_IDLE;
        rr_next = act_reg;
        over = req_reg.dir_in & (txn_res.length > req_reg.length);
        shrt = req_reg.dir_in & (txn_res.length < req_reg.length);
        if (txn_res.result != `RES_OK) begin
          ch_next[act_reg].result_code = txn_res.result;
          ch_next[act_reg].condition_change_flag = 1'b1;
        end else if (over) begin
          // oversize: fifo returned to its state at start
          ch_next[act_reg].result_code = `RES_OVERSIZE;
          ch_next[act_reg].condition_change_flag = 1'b1;
          wp_next[ua]  = snap_reg;
          cnt_next[ua] = cnt_next[ua] - rxc_next;
          if (ch_reg[act_reg].ctype != TYPE_ISO) ch_next[act_reg].transfer_run = 1'b0;
        end else begin
          rem_new = (32'(txn_res.length) > ch_reg[act_reg].transfer_remaining_count) ? '0 :
                    ch_reg[act_reg].transfer_remaining_count - 32'(txn_res.length);
          ch_next[act_reg].transfer_remaining_count = rem_new;
          if (shrt) begin
            // short: reserve the whole expected packet
            ch_next[act_reg].result_code = `RES_SHORT;
            ch_next[act_reg].condition_change_flag = 1'b1;
            wp_next[ua]  = snap_reg + AW'(req_reg.length);
            cnt_next[ua] = cnt_next[ua] + CW'(req_reg.length) - rxc_next;
            if (ch_reg[act_reg].ctype != TYPE_ISO) ch_next[act_reg].transfer_run = 1'b0;
          end
          if (req_reg.zero_len) begin
            ch_next[act_reg].transfer_run = 1'b0;
            ch_next[act_reg].transfer_count_done_flag = 1'b1;
            ch_next[act_reg].empty_packet_pending = 1'b0;
          end else if (rem_new == '0) begin
            // boundary end on general bulk or interrupt out keeps running with the option on
            if (!req_reg.dir_in && act_reg != 3'd0 && ch_reg[act_reg].auto_empty_packet_enable &&
                (ch_reg[act_reg].ctype inside {TYPE_BULK, TYPE_INTR}) &&
                req_reg.length == 16'(ch_reg[act_reg].max_packet_length))
              ch_next[act_reg].empty_packet_pending = 1'b1;
            else begin
              ch_next[act_reg].transfer_run = 1'b0;
              ch_next[act_reg].transfer_count_done_flag = 1'b1;
            end
          end
        end
      end
      default: st_next = ST_IDLE;
    endcase
    txb_next = mem_next[ua][rp_next[ua]];
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int c = 0; c < NCH; c++) ch_reg[c] <= '0;
      for (int a = 0; a < AREAS; a++) begin
        wp_reg[a]  <= '0;
        rp_reg[a]  <= '0;
        cnt_reg[a] <= '0;
      end
      sel_reg  <= '0;
      st_reg   <= ST_IDLE;
      act_reg  <= '0;
      rr_reg   <= '0;
      req_reg  <= '0;
      snap_reg <= '0;
      rxc_reg  <= '0;
      ack_reg  <= 1'b0;
      dat_reg  <= '0;
      step_reg <= '0;
      txb_reg  <= '0;
      dmab_reg <= '0;
    end else begin
      ch_reg   <= ch_next;
      wp_reg   <= wp_next;
      rp_reg   <= rp_next;
      cnt_reg  <= cnt_next;
      sel_reg  <= sel_next;
      st_reg   <= st_next;
      act_reg  <= act_next;
      rr_reg   <= rr_next;
      req_reg  <= req_next;
      snap_reg <= snap_next;
      rxc_reg  <= rxc_next;
      ack_reg  <= ack_next;
      dat_reg  <= dat_next;
      step_reg <= step_next;
      txb_reg  <= txb_next;
      dmab_reg <= dmab_next;
    end
  end

  // storage needs no reset; readers see only counted bytes
  always_ff @(posedge clock) begin
    mem_reg <= mem_next;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb_chk @(posedge clock); endclocking
  default disable iff (!arst_n);

  chan_s         act_ch;
  logic [CW-1:0] act_cnt;
  assign act_ch  = ch_reg[act_reg];
  assign act_cnt = cnt_reg[act_ch.area];

  sequence s_done_ok;
    st_reg == ST_BUSY && txn_done && txn_res.result == `RES_OK;
  endsequence
  sequence s_issue_start;
    $rose(st_reg == ST_ISSUE);
  endsequence

  chk_out_size: assert property (txn_valid && !txn_req.dir_in && !txn_req.zero_len |->
    txn_req.length == pkt_sz[act_reg]) else $error("out packet size wrong");
  chk_out_fill: assert property (s_issue_start ##0 !txn_req.dir_in && !txn_req.zero_len |->
    16'(act_cnt) >= txn_req.length) else $error("out started without data");
  chk_in_expect: assert property (txn_valid && txn_req.dir_in |->
    txn_req.length == pkt_sz[act_reg]) else $error("in expected size wrong");
  chk_in_space: assert property (s_issue_start ##0 txn_req.dir_in |->
    16'(FULL - act_cnt) >= 16'(act_ch.max_packet_length)) else $error("in without space");
  chk_count_drop: assert property (s_done_ok ##0 (txn_res.length <= txn_req.length) &&
    (32'(txn_res.length) <= act_ch.transfer_remaining_count) |=>
    act_ch.transfer_remaining_count == $past(act_ch.transfer_remaining_count) -
    32'($past(txn_res.length))) else $error("count not reduced by length");
  chk_done_stop: assert property ($stable(act_reg) &&
    $rose(act_ch.transfer_count_done_flag) |-> !act_ch.transfer_run)
    else $error("done flag with run still set");
  chk_oversize: assert property (s_done_ok ##0 txn_req.dir_in &&
    txn_res.length > txn_req.length |=> act_ch.result_code == `RES_OVERSIZE &&
    act_ch.condition_change_flag && (act_ch.ctype == TYPE_ISO || !act_ch.transfer_run))
    else $error("oversize not handled");
  chk_short: assert property (s_done_ok ##0 txn_req.dir_in &&
    txn_res.length < txn_req.length |=> act_ch.result_code == `RES_SHORT &&
    act_ch.condition_change_flag && (act_ch.ctype == TYPE_ISO || !act_ch.transfer_run))
    else $error("short packet not handled");
  chk_no_overfill: assert property (cnt_reg[wa] <= FULL)
    else $error("write area overfilled");
  chk_dma_last: assert property (dma_ack && dma_remaining_count == 32'h0000_0001 |=>
    dma_pause || dma_remaining_count != 32'h0000_0000) else $error("dma not paused");
  chk_zlp_keep: assert property ($stable(act_reg) && $rose(act_ch.empty_packet_pending) |->
    act_ch.transfer_run && act_ch.transfer_remaining_count == '0) else $error("zlp lost run");
  chk_zlp_send: assert property (txn_valid && txn_req.zero_len |->
    txn_req.length == 16'h0000 && !txn_req.dir_in) else $error("zlp not zero out");
  chk_zlp_end: assert property (s_done_ok ##0 txn_req.zero_len |=>
    !act_ch.transfer_run && act_ch.transfer_count_done_flag) else $error("zlp did not end");
  chk_first_bulk: assert property (ch_reg[1].ctype == TYPE_BULK ||
    ch_reg[1].ctype == TYPE_CTRL && !ch_reg[1].transfer_run && ch_reg[1].max_packet_length == '0
    && !$past(ch_reg[1].transfer_run)) else $error("first general not bulk");
  chk_ctrl_width: assert property (ch_reg[0].transfer_remaining_count[31:16] == 16'h0000)
    else $error("control count wider than two bytes");
endmodule

/* File: usb_link_partner.sv */
// Purpose: link partner model answering engine transactions
// Assumes: one transaction outstanding
// Notes:   in packets end short_by bytes early; above length reads as oversize
module usb_link_partner
  import usb_flow_pkg::*;
(
  // control
  input  wire logic       clock,
  input  wire logic       slow,
  input  wire logic [3:0] short_by,
  // engine link
  input  wire logic       txn_valid,
  output logic            txn_ready,
  input  wire txn_req_s   txn_req,
  output logic            txn_done,
  output txn_res_s        txn_res,
  output logic            tx_pop,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  int n;
  initial begin
    {txn_ready, txn_done, tx_pop, rx_valid} = '0;
    txn_res = '0;
    rx_byte = 8'h00;
    forever begin
      @(posedge clock);
      if (txn_valid) begin
        if (slow) repeat (3) @(posedge clock);
        txn_ready <= 1'b1;
        @(posedge clock);
        txn_ready <= 1'b0;
        n = txn_req.dir_in ? txn_req.length - short_by : txn_req.length;
        for (int i = 0; i < n; i++) begin
          tx_pop   <= !txn_req.dir_in;
          rx_valid <= txn_req.dir_in;
          rx_byte  <= 8'ha0 + i[7:0];
          @(posedge clock);
        end
        // idle data is scrambled so stale bytes are not trusted
        {tx_pop, rx_valid} <= 2'b00;
        rx_byte  <= ~rx_byte;
        txn_done <= 1'b1;
        txn_res  <= '{result: 4'h0, length: n[15:0]};
        @(posedge clock);
        txn_done <= 1'b0;
      end
    end
  end
endmodule

/* File: test_usb_host_channel_data_flow.sv */
// Purpose: self-checking bench for the channel data-flow engine
// Assumes: partner model on the link, dma_req driven for four cycles, dma data unchecked
// Notes:   sent bytes noted in a queue, popped by the watcher
module test_usb_host_channel_data_flow;
  import usb_flow_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, arst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, slow = 0, dma_req = 0;
  logic [3:0] short_by = 4'h2;
  logic [15:0] adr_i = 0;
  logic [31:0] dat_i = 0, dat_o, q, rnd = 32'h5ab4, dma_remaining_count;
  logic ack_o, txn_valid, txn_ready, txn_done, tx_pop, rx_valid, dma_ack, dma_pause;
  logic [7:0] tx_byte, rx_byte, dma_data, exp_q[$];
  txn_req_s txn_req;
  txn_res_s txn_res;
  int n_mismatch = 0, num_checks = 0, n_zlp = 0, n_dma = 0;
  usb_host_channel_data_flow i_usb_host_channel_data_flow (.clock, .arst_n, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .txn_valid, .txn_ready,
    .txn_req, .txn_done, .txn_res, .tx_pop, .tx_byte, .rx_valid, .rx_byte,
    .dma_req, .dma_ack, .dma_data, .dma_pause, .dma_remaining_count);
  usb_link_partner i_usb_link_partner (.clock, .slow, .short_by, .txn_valid,
    .txn_ready, .txn_req, .txn_done, .txn_res, .tx_pop, .rx_valid, .rx_byte);
  initial forever #12.5 clock = ~clock;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (ack_o !== 1'b1) begin
      n_mismatch++;
      test_done();
    end
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    wb(1'b0, a, 0);
    chk(q, e);
  endtask
  task automatic poll(input logic [15:0] a);
    for (int i = 0; i < 100 && q[1:0] == 2'b00; i++) wb(1'b0, a, 0);
  endtask
  always @(posedge clock) begin
    if (tx_pop) chk(tx_byte, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    if (txn_valid && txn_ready && txn_req.zero_len) n_zlp++;
    if (dma_ack) n_dma++;
  end
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    wb(1'b1, 16'h0000, 32'h0000_1332);
    rd(16'h0004, 32'h0000_0040);
    for (int w = 0; w < 2; w++) begin
      rnd = xs(rnd);
      for (int b = 0; b < 4; b++) exp_q.push_back(rnd[8*b +: 8]);
      wb(1'b1, 16'h0014, rnd);
    end
    rd(16'h0004, 32'h0000_0038);
    wb(1'b1, 16'h0124, 32'h0000_0008);
    wb(1'b1, 16'h0120, 32'h0008_0215);
    q = 0;
    poll(16'h0128);
    chk(q, 32'h0000_0001);
    chk(n_zlp, 1);
    chk(exp_q.size(), 0);
    rd(16'h0120, 32'h0008_0214);
    rd(16'h0124, 0);
    wb(1'b1, 16'h0128, 32'h0000_0003);
    rd(16'h0128, 0);
    slow <= 1'b1;
    wb(1'b1, 16'h0134, 32'h0000_0008);
    wb(1'b1, 16'h0130, 32'h0008_030b);
    q = 0;
    poll(16'h0138);
    chk(q, 32'h0000_0902);
    rd(16'h0130, 32'h0008_030a);
    rd(16'h0134, 2);
    rd(16'h0008, 8);
    chk(dma_remaining_count, 8);
    for (int i = 0; i < 6; i++) rd(16'h0010, 32'h0000_00a0 + i);
    chk(dma_pause, 0);
    dma_req <= 1'b1;
    repeat (4) @(posedge clock);
    dma_req <= 1'b0;
    chk(n_dma, 2);
    chk(dma_pause, 1);
    chk(dma_remaining_count, 0);
    short_by <= 4'hf;
    wb(1'b1, 16'h0144, 32'h0000_0008);
    wb(1'b1, 16'h0140, 32'h0008_040b);
    q = 0;
    poll(16'h0148);
    chk(q, 32'h0000_0802);
    rd(16'h0140, 32'h0008_040a);
    rd(16'h0144, 8);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    test_done();
  end
endmodule
